// ===== src/mdoc_top.v
// two meter digital outputs with source select and behaviour modes
`timescale 1ns/1ps
// What this block does
// - two outputs, each with own control, behaviour and on-time settings
// - external mode follows remote on and off commands only
// - demand mode pulses at end of selected demand interval
// - alarm mode turns on when an associated alarm triggers
// - energy mode emits pulses per selected energy quantity
// - normal behaviour (external and alarm modes) stays on until explicit off command
// - timed behaviour stays on for programmed on-time then turns off
// - on-time in whole seconds, 0 to 9999
// - latched hold (external and alarm modes) turns on by energize, off only by release or a config write
// - latched hold state survives control power loss and is restored
`include "mdoc_map.vh"

module mdoc_top #(
    parameter SEC_CYCLES = `MDOC_SEC_CYCLES
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata,
    input wire [5:0] demand_end,
    input wire [15:0] alarm_trig,
    input wire [7:0] energy_pulse,
    input wire [1:0] hold_restore,
    input wire restore_valid,
    output reg [1:0] hold_state,
    output reg first_switch_output,
    output reg second_switch_output
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [29:0] sync1_r;
reg [29:0] sync2_r;
reg rv1_r;
reg rv2_r;

always @(posedge clock) begin
    if (!rst_n) begin
        sync1_r <= 30'h0;
        sync2_r <= 30'h0;
        rv1_r <= 1'b0;
        rv2_r <= 1'b0;
    end else begin
        sync1_r <= {energy_pulse, alarm_trig, demand_end};
        sync2_r <= sync1_r;
        rv1_r <= restore_valid;
        rv2_r <= rv1_r;
    end
end

// ----------------------------------------
// edge detection
// ----------------------------------------
// starts low, the idle level of every input, so no false edge at reset
reg [29:0] prev_r;
wire [29:0] rise = sync2_r & ~prev_r;
wire [5:0] dmd_rise = rise[5:0];
wire [15:0] alm_rise = rise[21:6];
wire [7:0] nrg_rise = rise[29:22];

always @(posedge clock) begin
    if (!rst_n)
        prev_r <= 30'h0;
    else
        prev_r <= sync2_r;
end

// ----------------------------------------
// one-second tick
// ----------------------------------------
// free-running: the first second of a pulse may run short
reg [31:0] div_r;
reg tick_r;
always @(posedge clock) begin
    if (!rst_n) begin
        div_r <= 32'h0;
        tick_r <= 1'b0;
    end else if (div_r == SEC_CYCLES - 1) begin
        div_r <= 32'h0;
        tick_r <= 1'b1;
    end else begin
        div_r <= div_r + 32'h1;
        tick_r <= 1'b0;
    end
end

// ----------------------------------------
// retained hold state synchroniser
// ----------------------------------------
// the retained copy comes from an always-on store, not this clock
reg [1:0] hr1_r;
reg [1:0] hr2_r;
reg rv_prev_r;
wire restore_evt = rv2_r & ~rv_prev_r;

always @(posedge clock) begin
    if (!rst_n) begin
        hr1_r <= 2'h0;
        hr2_r <= 2'h0;
        rv_prev_r <= 1'b0;
    end else begin
        hr1_r <= hold_restore;
        hr2_r <= hr1_r;
        rv_prev_r <= rv2_r;
    end
end

// ----------------------------------------
// per-output state
// ----------------------------------------
wire [31:0] cfg_w;
wire [31:0] mask_w;
wire [27:0] ont_w;
wire [27:0] cnt_w;
wire [1:0] out_w;
wire [1:0] restored_w;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : gen_out
        // second output sits one register group above the first
        localparam [7:0] BASE = (g == 0) ? 8'h00 : 8'h04;

        reg [15:0] cfg_r;
        reg [15:0] mask_r;
        reg [13:0] ontime_r;
        reg [13:0] cnt_r;
        reg out_r;
        reg restored_r;
        reg [13:0] cnt_nxt;
        reg out_nxt;
        reg [1:0] ctrl;
        reg [1:0] beh;
        reg [2:0] src;
        reg evt;
        reg timed;
        wire [1:0] cmd = wdata[1:0];
        wire [13:0] ont_clamp;

        // ------------------------------------
        // write decode
        // ------------------------------------
        wire cfg_hit = wr_en && (addr == (`MDOC_CFG0_ADDR + BASE));
        wire cmd_hit = wr_en && (addr == (`MDOC_CMD0_ADDR + BASE));
        wire ont_hit = wr_en && (addr == (`MDOC_ONT0_ADDR + BASE));
        wire mask_hit = wr_en && (addr == (`MDOC_STAT0_ADDR + BASE));
        // values whose low 14 bits lie above range clamp to the top second count
        assign ont_clamp = (wdata[13:0] > `MDOC_ONTIME_MAX) ?
            `MDOC_ONTIME_MAX : wdata[13:0];

        // ------------------------------------
        // event that turns the output on
        // ------------------------------------
        // mode fields are decoded live from the stored config
        always @* begin
            ctrl = cfg_r[`MDOC_CFG_CTRL_LO+1:`MDOC_CFG_CTRL_LO];
            beh = cfg_r[`MDOC_CFG_BEH_LO+1:`MDOC_CFG_BEH_LO];
            src = cfg_r[`MDOC_CFG_SRC_LO+2:`MDOC_CFG_SRC_LO];
            evt = 1'b0;
            case (ctrl)
                `MDOC_CTRL_EXT: evt = cmd_hit && cmd == `MDOC_CMD_ON;
                `MDOC_CTRL_DMD: begin
                    // only six demand systems; higher selects stay quiet
                    if (src < 3'h6)
                        evt = dmd_rise[src];
                end
                `MDOC_CTRL_ALM: evt = |(alm_rise & mask_r);
                `MDOC_CTRL_NRG: evt = nrg_rise[src];
                default: evt = 1'b0;
            endcase
            // demand and energy always pulse for the on-time
            timed = beh == `MDOC_BEH_TIMED || ctrl == `MDOC_CTRL_DMD ||
                ctrl == `MDOC_CTRL_NRG;
        end

        // ------------------------------------
        // next output level and pulse count
        // ------------------------------------
        always @* begin
            out_nxt = out_r;
            cnt_nxt = cnt_r;
            // a new configuration starts from a quiet output
            if (cfg_hit) begin
                out_nxt = 1'b0;
                cnt_nxt = 14'h0000;
            end
            if (restore_evt && beh == `MDOC_BEH_HOLD) begin
                out_nxt = hr2_r[g];
            end else if (timed) begin
                if (evt && ontime_r != 14'h0000) begin
                    out_nxt = 1'b1;
                    cnt_nxt = ontime_r;
                end else if (out_r && tick_r) begin
                    if (cnt_r == 14'h0001)
                        out_nxt = 1'b0;
                    cnt_nxt = cnt_r - 14'h0001;
                end
            end else if (beh == `MDOC_BEH_HOLD) begin
                if (evt)
                    out_nxt = 1'b1;
                else if (cmd_hit && cmd == `MDOC_CMD_RELEASE)
                    out_nxt = 1'b0;
            end else begin
                if (evt)
                    out_nxt = 1'b1;
                else if (cmd_hit && cmd == `MDOC_CMD_OFF)
                    out_nxt = 1'b0;
            end
        end

        // ------------------------------------
        // registers
        // ------------------------------------
        always @(posedge clock) begin
            if (!rst_n) begin
                cfg_r <= `MDOC_CFG_RESET;
                mask_r <= 16'h0000;
                ontime_r <= 14'h0000;
                cnt_r <= 14'h0000;
                out_r <= 1'b0;
                restored_r <= 1'b0;
            end else begin
                if (cfg_hit)
                    cfg_r <= {8'h00, wdata[7:0]};
                if (ont_hit)
                    ontime_r <= ont_clamp;
                if (mask_hit)
                    mask_r <= wdata;
                // sticky until reset, so software sees a restore happened
                if (restore_evt && beh == `MDOC_BEH_HOLD)
                    restored_r <= 1'b1;
                cnt_r <= cnt_nxt;
                out_r <= out_nxt;
            end
        end

        assign cfg_w[16*g +: 16] = cfg_r;
        assign mask_w[16*g +: 16] = mask_r;
        assign ont_w[14*g +: 14] = ontime_r;
        assign cnt_w[14*g +: 14] = cnt_r;
        assign out_w[g] = out_r;
        assign restored_w[g] = restored_r;
    end
endgenerate

// ----------------------------------------
// register reads
// ----------------------------------------
wire [15:0] stat0_w = {cnt_w[13:0], restored_w[0], out_w[0]};
wire [15:0] stat1_w = {cnt_w[27:14], restored_w[1], out_w[1]};

reg [15:0] rd_nxt;
always @* begin
    case (addr)
        `MDOC_CFG0_ADDR: rd_nxt = cfg_w[15:0];
        `MDOC_ONT0_ADDR: rd_nxt = {2'h0, ont_w[13:0]};
        `MDOC_STAT0_ADDR: rd_nxt = mask_w[15:0];
        `MDOC_CMD0_ADDR: rd_nxt = stat0_w;
        `MDOC_CFG1_ADDR: rd_nxt = cfg_w[31:16];
        `MDOC_ONT1_ADDR: rd_nxt = {2'h0, ont_w[27:14]};
        `MDOC_STAT1_ADDR: rd_nxt = mask_w[31:16];
        `MDOC_CMD1_ADDR: rd_nxt = stat1_w;
        `MDOC_HOLD_ADDR: rd_nxt = {14'h0, out_w};
        default: rd_nxt = 16'h0000;
    endcase
end

// read data stand for one cycle only, zero otherwise
always @(posedge clock) begin
    if (!rst_n)
        rdata <= 16'h0000;
    else
        rdata <= rd_en ? rd_nxt : 16'h0000;
end

// ----------------------------------------
// outputs
// ----------------------------------------
always @(posedge clock) begin
    if (!rst_n) begin
        hold_state <= 2'h0;
        first_switch_output <= 1'b0;
        second_switch_output <= 1'b0;
    end else begin
        // retained copy for the always-on store kept outside
        hold_state <= out_w;
        first_switch_output <= out_w[0];
        second_switch_output <= out_w[1];
    end
end

endmodule // mdoc_top

// ===== src/mdoc_map.vh
// register offsets, field layouts, codes and timing counts for mdoc
`ifndef MDOC_MAP_VH
`define MDOC_MAP_VH
// register word addresses (per output: base + 4 * output index)
`define MDOC_CFG0_ADDR 8'h00
`define MDOC_CMD0_ADDR 8'h01
`define MDOC_ONT0_ADDR 8'h02
`define MDOC_STAT0_ADDR 8'h03
`define MDOC_CFG1_ADDR 8'h04
`define MDOC_CMD1_ADDR 8'h05
`define MDOC_ONT1_ADDR 8'h06
`define MDOC_STAT1_ADDR 8'h07
`define MDOC_HOLD_ADDR 8'h08
// config fields
`define MDOC_CFG_CTRL_LO 0
`define MDOC_CFG_BEH_LO 2
`define MDOC_CFG_SRC_LO 4
`define MDOC_CFG_RESET 16'h0000
// control modes
`define MDOC_CTRL_EXT 2'h0
`define MDOC_CTRL_DMD 2'h1
`define MDOC_CTRL_ALM 2'h2
`define MDOC_CTRL_NRG 2'h3
// behaviour modes
`define MDOC_BEH_NORM 2'h0
`define MDOC_BEH_TIMED 2'h1
`define MDOC_BEH_HOLD 2'h2
// command codes written to the command register
`define MDOC_CMD_OFF 2'h0
`define MDOC_CMD_ON 2'h1
`define MDOC_CMD_RELEASE 2'h2
// timing
`define MDOC_ONTIME_MAX 14'h270f
`define MDOC_CLK_HZ 50000000
`define MDOC_SEC_CYCLES (`MDOC_CLK_HZ * 1)
`define MDOC_NRG_PULSE_CYCLES 16'h0001
`endif

// ===== verification/mdoc_pulse_rx.sv
// pulse-counting receiver on one digital output
`timescale 1ns/1ps
module mdoc_pulse_rx (
    input wire clock,
    input wire rst_n,
    input wire line_on,
    output reg [15:0] pulses
);
    reg last_r;
    // each on edge is one demand boundary, one alarm trigger or one energy quantum
    always @(posedge clock) begin
        if (!rst_n) begin
            last_r <= 1'b0;
            pulses <= 16'h0000;
        end else begin
            last_r <= line_on;
            if (line_on && !last_r)
                pulses <= pulses + 16'h0001;
        end
    end
endmodule // mdoc_pulse_rx

// ===== verification/mdoc_monitor.sv
// assertion checker for the two digital outputs
`timescale 1ns/1ps
module mdoc_monitor (
    input wire clock,
    input wire rst_n,
    input wire [7:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rdata,
    input wire first_switch_output,
    input wire second_switch_output
);
    reg [3:0] c0_r;
    reg [3:0] c1_r;
    wire w0 = wr_en && addr == 8'h01;
    wire w1 = wr_en && addr == 8'h05;
    // shadow of the mode fields, cleared like the real config
    always @(posedge clock) begin
        if (!rst_n) begin
            c0_r <= 4'h0;
            c1_r <= 4'h0;
        end else if (wr_en && addr == 8'h00) begin
            c0_r <= wdata[3:0];
        end else if (wr_en && addr == 8'h04) begin
            c1_r <= wdata[3:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_ON0: assert property (w0 && wdata[1:0] == 2'h1 && c0_r == 4'h0
        ##1 !wr_en |-> ##1 first_switch_output) else $error("on0 late");
    AST_OFF0: assert property (w0 && wdata[1:0] == 2'h0 && c0_r == 4'h0
        ##1 !wr_en |-> ##1 !first_switch_output) else $error("off0 late");
    AST_ON1: assert property (w1 && wdata[1:0] == 2'h1 && c1_r == 4'h0
        ##1 !wr_en |-> ##1 second_switch_output) else $error("on1 late");
    AST_HOLD_IGN: assert property (w0 && wdata[1:0] == 2'h0 && c0_r == 4'h8
        && first_switch_output ##1 !wr_en |-> ##1 first_switch_output)
        else $error("hold dropped");
    AST_REL: assert property (w0 && wdata[1:0] == 2'h2 && c0_r == 4'h8
        ##1 !wr_en |-> ##1 !first_switch_output) else $error("no release");
    AST_EXT0: assert property (c0_r == 4'h0 && $stable(c0_r) && !$past(wr_en)
        && !$past(wr_en, 2) |-> $stable(first_switch_output))
        else $error("out0 moved");
    AST_EXT1: assert property (c1_r == 4'h0 && $stable(c1_r) && !$past(wr_en)
        && !$past(wr_en, 2) |-> $stable(second_switch_output))
        else $error("out1 moved");
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 16'h0000)
        else $error("rdata stray");
endmodule // mdoc_monitor
bind mdoc_top mdoc_monitor mdoc_monitor_inst (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .first_switch_output(first_switch_output),
    .second_switch_output(second_switch_output));

// ===== verification/mdoc_top_tb.sv
// self-checking bench for the digital output block
`timescale 1ns/1ps
module mdoc_top_tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg restore_valid = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [15:0] wdata = 16'h0000;
    reg [5:0] demand_end = 6'h00;
    reg [15:0] alarm_trig = 16'h0000;
    reg [7:0] energy_pulse = 8'h00;
    reg [1:0] hold_restore = 2'h0;
    reg [15:0] d;
    reg [15:0] p;
    wire [15:0] rdata;
    wire [15:0] pulses;
    wire [1:0] hold_state;
    wire o0;
    wire o1;
    integer err_total = 0;
    integer n_tests = 0;
    integer w;
    integer k;
    // short second so timed pulses stay a few dozen cycles
    mdoc_top #(.SEC_CYCLES(10)) mdoc_top_inst (.clock(clock), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .demand_end(demand_end), .alarm_trig(alarm_trig),
        .energy_pulse(energy_pulse), .hold_restore(hold_restore),
        .restore_valid(restore_valid), .hold_state(hold_state),
        .first_switch_output(o0), .second_switch_output(o1));
    mdoc_pulse_rx mdoc_pulse_rx_inst (.clock(clock), .rst_n(rst_n),
        .line_on(o0), .pulses(pulses));
    initial begin
        forever #10 clock = ~clock;
    end
    task step(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [15:0] v);
        begin
            @(posedge clock);
            addr <= a;
            wdata <= v;
            wr_en <= 1'b1;
            @(posedge clock);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clock);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clock);
            rd_en <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task chk(input [63:0] nm, input [15:0] s, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("mismatch %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    task wid;
        begin
            w = 0;
            repeat (60) begin
                step(1);
                if (o0 === 1'b1)
                    w = w + 1;
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task t_ext;
        begin
            wr(8'h01, 16'h0001);
            step(2);
            chk("ext_on", {o0, o1}, 16'h0002);
            wr(8'h05, 16'h0001);
            wr(8'h01, 16'h0000);
            step(2);
            chk("ext_off", {o0, o1}, 16'h0001);
            wr(8'h05, 16'h0000);
            $display("test ext done");
        end
    endtask
    task t_timed;
        begin
            wr(8'h00, 16'h0004);
            wr(8'h02, 16'h0003);
            wr(8'h01, 16'h0001);
            wid;
            chk("timed", {15'h0, w >= 20 && w <= 30}, 16'h0001);
            wr(8'h02, 16'h0000);
            wr(8'h01, 16'h0001);
            wid;
            chk("zero", w[15:0], 16'h0000);
            wr(8'h02, 16'h2710);
            rd(8'h02);
            chk("clamp", d, 16'h270f);
            rd(8'h20);
            chk("unmap", d, 16'h0000);
            $display("test timed done");
        end
    endtask
    task t_src;
        begin
            wr(8'h02, 16'h0001);
            wr(8'h03, 16'h0001);
            for (k = 1; k < 4; k = k + 1) begin
                wr(8'h00, k[15:0] | 16'h0004);
                p = pulses;
                demand_end <= 6'h01;
                alarm_trig <= 16'h0001;
                energy_pulse <= 8'h01;
                step(30);
                chk("src", pulses - p, 16'h0001);
                demand_end <= 6'h00;
                alarm_trig <= 16'h0000;
                energy_pulse <= 8'h00;
                step(15);
            end
            $display("test src done");
        end
    endtask
    task t_hold;
        begin
            wr(8'h00, 16'h0008);
            wr(8'h01, 16'h0001);
            wr(8'h01, 16'h0000);
            step(2);
            chk("hold", {hold_state, o0}, 16'h0003);
            rst_n <= 1'b0;
            hold_restore <= 2'h1;
            step(2);
            rst_n <= 1'b1;
            wr(8'h00, 16'h0008);
            restore_valid <= 1'b1;
            step(6);
            chk("restore", {15'h0, o0}, 16'h0001);
            restore_valid <= 1'b0;
            wr(8'h01, 16'h0002);
            step(2);
            chk("release", {15'h0, o0}, 16'h0000);
            wr(8'h03, 16'h0001);
            wr(8'h00, 16'h000a);
            alarm_trig <= 16'h0001;
            step(6);
            alarm_trig <= 16'h0000;
            step(6);
            chk("alm_hold", {15'h0, o0}, 16'h0001);
            wr(8'h01, 16'h0002);
            step(2);
            chk("alm_rel", {15'h0, o0}, 16'h0000);
            $display("test hold done");
        end
    endtask
    initial begin
        step(2);
        rst_n <= 1'b1;
        t_ext;
        t_timed;
        t_src;
        t_hold;
        summarize;
    end
endmodule // mdoc_top_tb
